// >>> uvcts_defs.svh
// Constants for the UV conversion timing and scaling block.
// Assumes inclusion by uvcts_core only.
`ifndef UVCTS_DEFS_SVH
`define UVCTS_DEFS_SVH

// ==========================================================
// Clock and conversion lengths
// ==========================================================
`define UVCTS_CLK_PERIOD_NS    100
`define UVCTS_BASE_LEN_EXP     5'h0A
`define UVCTS_SHORT_LEN_CODE   4'hF
`define UVCTS_SHORT_LEN_M1     24'h0003FF
`define UVCTS_MAX_GAIN_CODE    4'hB

// ==========================================================
// Field widths and reset values
// ==========================================================
`define UVCTS_ACC_W            24
`define UVCTS_RES_W            16
`define UVCTS_NUM_CH           3
`define UVCTS_ACC_MAX          24'hFFFFFF
`define UVCTS_RST_RESULT       16'h0000
`define UVCTS_RST_COUNT        24'h000000

`endif

// >>> uvcts_pkg.sv
// Types shared by the UV conversion timing and scaling block.
// Assumes it is compiled before the core and the bench.
package uvcts_pkg;

   // ==========================================================
   // Measurement modes and sequencer states
   // ==========================================================
   typedef enum logic [1:0] {
      UVCTS_FREE_RUNNING,
      UVCTS_COMMAND,
      UVCTS_TRIGGER_STARTED,
      UVCTS_TRIGGER_GATED
   } uvcts_mode_t;

   typedef enum logic {
      UVCTS_IDLE,
      UVCTS_INTEGRATE
   } uvcts_state_t;

endpackage : uvcts_pkg

// >>> uvcts_core.sv
// Conversion sequencer, channel counters, prescaler and elapsed-clock counter.
// Assumes the converter pulses and overdrive monitors come from an analog front end;
// the trigger pin and the overdrive monitors are asynchronous and are synchronised here.
//
// What this block does
// - Gated mode, count enable set, no wrap: channel count can never exceed the captured elapsed-clock count.
// - Timed modes: length code sets conversion cycles and so maximum resolution.
// - Gated mode: length code does not affect conversion timing.
// - Codes 7 to 14 run beyond 2^16 clocks, giving 17 to 24 bits.
// - Prescaler off: store the low 16 bits of each internal result.
// - Gain code 0 is 2048x, each step halves, code 11 is 1x.
// - Clock select 0 to 3 picks 1.024, 2.048, 4.096, 8.192 MHz.
// - Faster clock selections cap the highest gain steps to a lower gain.
// - Any channel overdrive during a conversion sets the overdrive flag.
// - Prescaler on: divide result by 2^(1+exponent), exponent 0 to 7.
// - Prescaler on: stored value is a 16-bit window, exponent 2 gives 18:3.
// - Internal counts are 24 bits wide, stored results 16 bits.
// - Gated mode: trigger pin alone defines the integration interval.
// - Count enable set: count system clocks over the conversion, 24 bits.
// - Elapsed count is stored in the same update as channel results.
`timescale 1ns/100ps
`include "uvcts_defs.svh"

module uvcts_core (
   input  wire logic                  clock,
   input  wire logic                  rst_n,
   input  wire uvcts_pkg::uvcts_mode_t measure_mode,
   input  wire logic                  start_command,
   input  wire logic                  external_trigger_pin,
   input  wire logic [3:0]            integration_length_code,
   input  wire logic [3:0]            responsivity_code,
   input  wire logic [1:0]            system_clock_select,
   input  wire logic [2:0]            prescale_exponent,
   input  wire logic                  prescale_enable,
   input  wire logic                  elapsed_clock_count_enable,
   input  wire logic [2:0]            converter_pulse,
   input  wire logic [2:0]            channel_overdrive,
   input  wire logic                  overdrive_flag_clear,
   input  wire logic                  overflow_flag_clear,
   output logic [15:0]                channel_result_0,
   output logic [15:0]                channel_result_1,
   output logic [15:0]                channel_result_2,
   output logic [23:0]                elapsed_clock_count,
   output logic                       result_ready,
   output logic                       conversion_busy,
   output logic [3:0]                 applied_gain_code,
   output logic [3:0]                 applied_gain_log2,
   output logic [1:0]                 applied_clock_select,
   output logic                       converter_overdrive_flag,
   output logic                       elapsed_clock_overflow_flag
);

   // ==========================================================
   // Input synchronisers
   // ==========================================================
   // Three stages per asynchronous input; the filtered level moves only
   // when stages two and three agree, so a one-stage glitch is dropped.
   logic [3:0] sync_a;
   logic [3:0] sync_b;
   logic [3:0] sync_c;
   logic [3:0] filt;
   logic [3:0] filt_prev;

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         sync_a    <= 4'h0;
         sync_b    <= 4'h0;
         sync_c    <= 4'h0;
         filt      <= 4'h0;
         filt_prev <= 4'h0;
      end else begin
         sync_a    <= {external_trigger_pin, channel_overdrive};
         sync_b    <= sync_a;
         sync_c    <= sync_b;
         filt      <= (sync_b & sync_c) | (filt & (sync_b ^ sync_c));
         filt_prev <= filt;
      end
   end

   wire       trig_rise = filt[3] & ~filt_prev[3];
   wire       trig_fall = ~filt[3] & filt_prev[3];
   wire [2:0] overdrive = filt[2:0];

   // ==========================================================
   // Sequencer
   // ==========================================================
   uvcts_pkg::uvcts_state_t state;
   uvcts_pkg::uvcts_state_t next_state;
   logic                    gated_q;
   logic                    count_en_q;
   logic                    prescale_q;
   logic [2:0]              exponent_q;
   logic [23:0]             remaining;
   logic [23:0]             len_m1_q;

   wire busy = (state == uvcts_pkg::UVCTS_INTEGRATE);

   // Start source depends on the mode; a trigger during a timed conversion is ignored.
   wire start_src = (measure_mode == uvcts_pkg::UVCTS_FREE_RUNNING) ? 1'b1 :
                    (measure_mode == uvcts_pkg::UVCTS_COMMAND) ? start_command : trig_rise;
   wire start_now = ~busy & start_src;
   wire end_now   = busy & (gated_q ? trig_fall : (remaining == 24'h000000));

   // Gated conversions stop on the fall itself, so that cycle is not counted.
   wire count_cyc = busy & ~(gated_q & end_now);

   // Conversion length, a power of two above the base, except the short code.
   wire [4:0]  len_exp  = {1'b0, integration_length_code} + `UVCTS_BASE_LEN_EXP;
   wire [24:0] len_full = 25'h0000001 << len_exp;
   wire [23:0] len_m1   = (integration_length_code == `UVCTS_SHORT_LEN_CODE) ?
                          `UVCTS_SHORT_LEN_M1 : 24'(len_full - 25'h0000001);

   always_comb begin
      next_state = state;
      case (state)
         uvcts_pkg::UVCTS_IDLE:      if (start_now) next_state = uvcts_pkg::UVCTS_INTEGRATE;
         uvcts_pkg::UVCTS_INTEGRATE: if (end_now) next_state = uvcts_pkg::UVCTS_IDLE;
         default:                    next_state = uvcts_pkg::UVCTS_IDLE;
      endcase
   end

   // Gain is capped to the code equal to the clock select, so faster clocks lose top steps.
   wire [3:0] gain_capped = (responsivity_code < {2'h0, system_clock_select}) ?
                            {2'h0, system_clock_select} : responsivity_code;
   wire [3:0] gain_eff    = (gain_capped > `UVCTS_MAX_GAIN_CODE) ?
                            `UVCTS_MAX_GAIN_CODE : gain_capped;

   // Configuration is sampled only at start so a running conversion never sees a change.
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         state                <= uvcts_pkg::UVCTS_IDLE;
         gated_q              <= 1'b0;
         count_en_q           <= 1'b0;
         prescale_q           <= 1'b0;
         exponent_q           <= 3'h0;
         len_m1_q             <= `UVCTS_RST_COUNT;
         applied_gain_code    <= 4'h0;
         applied_clock_select <= 2'h0;
      end else begin
         state <= next_state;
         if (start_now) begin
            gated_q              <= (measure_mode == uvcts_pkg::UVCTS_TRIGGER_GATED);
            count_en_q           <= elapsed_clock_count_enable;
            prescale_q           <= prescale_enable;
            exponent_q           <= prescale_exponent;
            len_m1_q             <= len_m1;
            applied_gain_code    <= gain_eff;
            applied_clock_select <= system_clock_select;
         end
      end
   end

   // Down-counter of the timed length; it runs in gated mode too but is not looked at.
   always_ff @(posedge clock) begin
      if (!rst_n) remaining <= `UVCTS_RST_COUNT;
      else if (start_now) remaining <= len_m1;
      else if (busy) remaining <= remaining - 24'h000001;
   end

   assign applied_gain_log2 = `UVCTS_MAX_GAIN_CODE - applied_gain_code;
   assign conversion_busy   = busy;

   // ==========================================================
   // Elapsed-clock counter
   // ==========================================================
   logic [23:0] elapsed;
   wire         elapsed_step = count_cyc & count_en_q;
   wire [23:0]  next_elapsed = elapsed_step ? elapsed + 24'h000001 : elapsed;
   wire         elapsed_wrap = elapsed_step & (elapsed == `UVCTS_ACC_MAX);

   // Plain 24-bit wrap: an overflow restarts from zero and raises the flag.
   always_ff @(posedge clock) begin
      if (!rst_n) elapsed <= `UVCTS_RST_COUNT;
      else if (start_now) elapsed <= `UVCTS_RST_COUNT;
      else elapsed <= next_elapsed;
   end

   // ==========================================================
   // Channel counters and prescaler
   // ==========================================================
   logic [23:0] acc [`UVCTS_NUM_CH];
   logic [23:0] next_acc [`UVCTS_NUM_CH];
   logic [15:0] result [`UVCTS_NUM_CH];
   wire  [3:0]  shift_amt = {1'b0, exponent_q} + 4'h1;

   genvar ch;
   generate
      for (ch = 0; ch < `UVCTS_NUM_CH; ch++) begin : g_ch
         // Saturate rather than wrap so a full-scale input never reads as dark with the prescaler on at exponent 7.
         wire        add   = count_cyc & converter_pulse[ch] & (acc[ch] != `UVCTS_ACC_MAX);
         // Without the prescaler the low word is kept; with it the window moves up.
         wire [23:0] shift = prescale_q ? (next_acc[ch] >> shift_amt) : next_acc[ch];
         assign next_acc[ch] = add ? acc[ch] + 24'h000001 : acc[ch];

         always_ff @(posedge clock) begin
            if (!rst_n) acc[ch] <= `UVCTS_RST_COUNT;
            else if (start_now) acc[ch] <= `UVCTS_RST_COUNT;
            else acc[ch] <= next_acc[ch];
         end

         always_ff @(posedge clock) begin
            if (!rst_n) result[ch] <= `UVCTS_RST_RESULT;
            else if (end_now) result[ch] <= shift[15:0];
         end
      end
   endgenerate

   assign channel_result_0 = result[0];
   assign channel_result_1 = result[1];
   assign channel_result_2 = result[2];

   // ==========================================================
   // Result update and status flags
   // ==========================================================
   // Results and elapsed count load in one edge; set beats clear on both flags.
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         elapsed_clock_count         <= `UVCTS_RST_COUNT;
         result_ready                <= 1'b0;
         converter_overdrive_flag    <= 1'b0;
         elapsed_clock_overflow_flag <= 1'b0;
      end else begin
         result_ready <= end_now;
         if (end_now) elapsed_clock_count <= next_elapsed;
         if (busy && (overdrive != 3'h0)) converter_overdrive_flag <= 1'b1;
         else if (overdrive_flag_clear) converter_overdrive_flag <= 1'b0;
         if (elapsed_wrap) elapsed_clock_overflow_flag <= 1'b1;
         else if (overflow_flag_clear) elapsed_clock_overflow_flag <= 1'b0;
      end
   end

   // ==========================================================
   // Checks
   // ==========================================================
   // Helper: busy cycles since start, and whether the elapsed counter wrapped.
   logic [24:0] busy_cycles;
   logic        wrapped;
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         busy_cycles <= 25'h0000000;
         wrapped     <= 1'b0;
      end else if (start_now) begin
         busy_cycles <= 25'h0000000;
         wrapped     <= 1'b0;
      end else begin
         if (busy) busy_cycles <= busy_cycles + 25'h0000001;
         if (elapsed_wrap) wrapped <= 1'b1;
      end
   end

   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);

   property p_gated_max;
      end_now && gated_q && count_en_q && !wrapped && !elapsed_wrap
         |-> next_acc[0] <= next_elapsed;
   endproperty
   a_gated_max: assert property (p_gated_max) else $error("count above elapsed");

   property p_timed_len;
      end_now && !gated_q |-> busy_cycles == {1'b0, len_m1_q};
   endproperty
   a_timed_len: assert property (p_timed_len) else $error("timed length wrong");

   property p_gated_hold;
      busy && gated_q && !trig_fall |=> busy;
   endproperty
   a_gated_hold: assert property (p_gated_hold) else $error("gated ended early");

   property p_low_word;
      end_now && !prescale_q |=> result[0] == $past(next_acc[0][15:0]);
   endproperty
   a_low_word: assert property (p_low_word) else $error("low word not stored");

   property p_window;
      end_now && prescale_q && exponent_q == 3'h2
         |=> result[1] == $past(next_acc[1][18:3]);
   endproperty
   a_window: assert property (p_window) else $error("prescale window wrong");

   property p_gain_cap;
      busy |-> applied_gain_code >= {2'h0, applied_clock_select}
               && applied_gain_code <= `UVCTS_MAX_GAIN_CODE;
   endproperty
   a_gain_cap: assert property (p_gain_cap) else $error("gain not capped");

   property p_cfg_stable;
      busy ##1 busy |-> $stable(applied_gain_code) && $stable(prescale_q) && $stable(len_m1_q);
   endproperty
   a_cfg_stable: assert property (p_cfg_stable) else $error("config changed mid run");

   property p_overdrive;
      busy && overdrive != 3'h0 |=> converter_overdrive_flag;
   endproperty
   a_overdrive: assert property (p_overdrive) else $error("overdrive missed");

   property p_wrap;
      elapsed_wrap && !start_now |=> elapsed == 24'h000000 && elapsed_clock_overflow_flag;
   endproperty
   a_wrap: assert property (p_wrap) else $error("overflow not handled");

   property p_same_update;
      end_now |=> result_ready && elapsed_clock_count == $past(next_elapsed) ##1 !result_ready;
   endproperty
   a_same_update: assert property (p_same_update) else $error("update not aligned");

endmodule : uvcts_core

// >>> uvcts_host.sv
// Host model: drives the trigger pin and owns the gain code.
// Assumes its tasks are called just after a rising clock edge.
`timescale 1ns/100ps

module uvcts_host (
   input  wire logic       clock,
   output logic            external_trigger_pin,
   output logic [3:0]      responsivity_code
);
   // ==========================================================
   // Pin and gain state
   // ==========================================================
   // The pin rests low so that no stray edge reaches the filter.
   initial begin
      external_trigger_pin = 1'b0;
      responsivity_code    = 4'h0;
   end

   // Holds the pin high for n whole cycles; the host alone sets the span.
   task automatic gate(input int n);
      external_trigger_pin = 1'b1;
      repeat (n) @(posedge clock);
      #10 external_trigger_pin = 1'b0;
   endtask : gate

   // Loads a new gain code.
   task automatic set_gain(input logic [3:0] g);
      responsivity_code = g;
   endtask : set_gain

   // A higher code means lower gain, so an overdrive moves the code up.
   task automatic back_off();
      if (responsivity_code < 4'hB) responsivity_code = responsivity_code + 4'h1;
   endtask : back_off
endmodule : uvcts_host

// >>> uvcts_core_tb_top.sv
// Self-checking bench for the conversion timing and scaling core.
// Assumes the host model drives the trigger pin and the gain code.
`timescale 1ns/100ps

module uvcts_core_tb_top;
   // ==========================================================
   // Signals and reference state
   // ==========================================================
   uvcts_pkg::uvcts_mode_t measure_mode;
   logic        clock = 1'b0;
   logic        rst_n, start_command, external_trigger_pin;
   logic        prescale_enable, elapsed_clock_count_enable;
   logic        overdrive_flag_clear, overflow_flag_clear;
   logic [3:0]  integration_length_code, responsivity_code;
   logic [3:0]  applied_gain_code, applied_gain_log2;
   logic [1:0]  system_clock_select, applied_clock_select;
   logic [2:0]  prescale_exponent, converter_pulse, channel_overdrive;
   logic [15:0] channel_result_0, channel_result_1, channel_result_2;
   logic [23:0] elapsed_clock_count;
   logic        result_ready, conversion_busy;
   logic        converter_overdrive_flag, elapsed_clock_overflow_flag;
   logic [15:0] res [3];
   int          errors, comparisons, busy_cyc;
   int          cnt [3];
   integer      seed = 32'hAF6F;

   assign res[0] = channel_result_0;
   assign res[1] = channel_result_1;
   assign res[2] = channel_result_2;

   uvcts_core u_uvcts_core (.clock, .rst_n, .measure_mode, .start_command,
      .external_trigger_pin, .integration_length_code, .responsivity_code,
      .system_clock_select, .prescale_exponent, .prescale_enable,
      .elapsed_clock_count_enable, .converter_pulse, .channel_overdrive,
      .overdrive_flag_clear, .overflow_flag_clear, .channel_result_0,
      .channel_result_1, .channel_result_2, .elapsed_clock_count, .result_ready,
      .conversion_busy, .applied_gain_code, .applied_gain_log2,
      .applied_clock_select, .converter_overdrive_flag, .elapsed_clock_overflow_flag);

   uvcts_host u_uvcts_host (.clock, .external_trigger_pin, .responsivity_code);

   // A 100 ns period.
   always #50 clock = ~clock;

   // Reference model: one count per busy cycle and per pulse seen in it.
   // Sampled mid-cycle, where busy and the pulses are settled.
   always @(negedge clock) begin
      if (conversion_busy === 1'b1) begin
         busy_cyc++;
         for (int c = 0; c < 3; c++) cnt[c] += converter_pulse[c];
      end
   end

   // ==========================================================
   // Checking helpers
   // ==========================================================
   task automatic check(input logic [23:0] seen, input logic [23:0] exp);
      comparisons++;
      if (seen !== exp) begin
         errors++;
         $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic close_out();
      $display("errors %0d comparisons %0d", errors, comparisons);
      if (errors == 0 && comparisons > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : close_out

   // Stored value: low 16 bits, or a window shifted by exponent plus one.
   function automatic logic [15:0] scale(int v, logic pen, logic [2:0] e);
      return pen ? 16'(v >> (e + 1)) : 16'(v);
   endfunction : scale

   // Runs cycles until results arrive; the bound turns a hang into a mismatch.
   task automatic convert(input logic rnd, input int od, input int mid);
      int i;
      for (i = 0; i < 3000 && result_ready !== 1'b1; i++) begin
         @(posedge clock);
         #10;
         start_command = 1'b0;
         converter_pulse = rnd ? 3'($random(seed)) : 3'h7;
         channel_overdrive = (i >= 100 && i < 108 && od >= 0) ? 3'(1 << od) : 3'h0;
         // Scrambling settings mid-run must not disturb the running conversion.
         if (i == mid) begin
            integration_length_code = 4'($random(seed));
            system_clock_select = 2'($random(seed));
            prescale_exponent = 3'($random(seed));
            prescale_enable = ~prescale_enable;
            u_uvcts_host.set_gain(4'($random(seed)));
         end
      end
      check(24'(i < 3000), 24'h000001);
   endtask : convert

   // One command-mode conversion with random pulses and full result checks.
   task automatic run_cmd(input logic [3:0] len, gain, input logic [1:0] clk,
                          input logic pen, input logic [2:0] pexp, input int od);
      logic [3:0] g;
      g = (gain > {2'b00, clk}) ? gain : {2'b00, clk};
      if (g > 4'hB) g = 4'hB;
      @(posedge clock);
      #10;
      integration_length_code = len;
      system_clock_select = clk;
      prescale_enable = pen;
      prescale_exponent = pexp;
      u_uvcts_host.set_gain(gain);
      start_command = 1'b1;
      busy_cyc = 0;
      cnt = '{0, 0, 0};
      convert(1'b1, od, 50);
      check(24'(busy_cyc), 24'h000400);
      check(elapsed_clock_count, 24'(busy_cyc));
      for (int c = 0; c < 3; c++) check(24'(res[c]), 24'(scale(cnt[c], pen, pexp)));
      check(24'(applied_gain_code), 24'(g));
      check(24'(applied_gain_log2), 24'(4'hB - g));
      check(24'(applied_clock_select), 24'(clk));
      check(24'(converter_overdrive_flag), 24'(od >= 0));
      if (od >= 0) u_uvcts_host.back_off();
      @(posedge clock);
      #10;
      overdrive_flag_clear = 1'b1;
      @(posedge clock);
      #10;
      overdrive_flag_clear = 1'b0;
      check(24'(converter_overdrive_flag), 24'h000000);
   endtask : run_cmd

   // ==========================================================
   // Main sequence
   // ==========================================================
   initial begin
      rst_n = 1'b0;
      measure_mode = uvcts_pkg::UVCTS_COMMAND;
      start_command = 1'b0;
      integration_length_code = 4'hF;
      system_clock_select = 2'h0;
      prescale_exponent = 3'h0;
      prescale_enable = 1'b0;
      elapsed_clock_count_enable = 1'b1;
      converter_pulse = 3'h0;
      channel_overdrive = 3'h0;
      overdrive_flag_clear = 1'b0;
      overflow_flag_clear = 1'b0;
      repeat (3) @(posedge clock);
      #10 rst_n = 1'b1;
      // Every gain code at least once, codes 0 to 3 twice, random clock and prescaler, some overdrives.
      // Every fourth run forces the prescaler on at exponent two for the window.
      for (int k = 0; k < 20; k++)
         run_cmd(k[0] ? 4'hF : 4'h0, 4'(k), 2'($random(seed)),
                 1'($random(seed)) | (k % 4 == 1), (k % 4 == 1) ? 3'h2 : 3'($random(seed)),
                 (k % 5 == 2) ? k % 3 : -1);
      // Trigger started, then gated with the elapsed count off and on.
      for (int m = 2; m < 5; m++) begin
         @(posedge clock);
         #10;
         measure_mode = (m == 2) ? uvcts_pkg::UVCTS_TRIGGER_STARTED
                                 : uvcts_pkg::UVCTS_TRIGGER_GATED;
         // Gated runs use a short code but a longer gate, so the code must not end them.
         integration_length_code = (m == 2) ? 4'hF : 4'h0;
         prescale_enable = 1'b0;
         elapsed_clock_count_enable = (m == 4);
         converter_pulse = 3'h7;
         busy_cyc = 0;
         cnt = '{0, 0, 0};
         u_uvcts_host.gate((m == 2) ? 5 : 1100);
         convert(1'b0, -1, -1);
         check(24'(res[0]), 24'(cnt[0] - (m > 2)));
         if (m == 2) check(24'(busy_cyc), 24'h000400);
         else check(24'(busy_cyc > 1090 && busy_cyc < 1110), 24'h000001);
         if (m > 2) check(elapsed_clock_count, 24'((m == 4) ? busy_cyc - 1 : 0));
      end
      // Free running restarts at once after each result.
      @(posedge clock);
      #10;
      measure_mode = uvcts_pkg::UVCTS_FREE_RUNNING;
      busy_cyc = 0;
      cnt = '{0, 0, 0};
      convert(1'b0, -1, -1);
      check(24'(busy_cyc), 24'h000400);
      check(24'(res[2]), 24'(cnt[2]));
      @(posedge clock);
      #10;
      check(24'(conversion_busy), 24'h000001);
      check(24'(elapsed_clock_overflow_flag), 24'h000000);
      close_out();
   end

   // Watchdog: the whole run needs about 25000 cycles.
   initial begin
      repeat (50000) @(posedge clock);
      errors++;
      close_out();
   end
endmodule : uvcts_core_tb_top
